// File: inc/cbt_pkg.sv
// constants for the can bit-timing and receive-history block
// assumes a 16-bit byte address space reached over avalon-mm
package cbt_pkg;

   // ----------------------------------------------------------
   // bus geometry
   // ----------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;

   // ----------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------
   localparam logic [15:0] OFS_RX_GET = 16'hff60;
   localparam logic [15:0] OFS_BIT_TIMING = 16'hff9c;
   localparam logic [15:0] OFS_PRESCALER = 16'hff50;
   localparam logic [15:0] OFS_LAST_IN = 16'hff54;
   localparam logic [15:0] OFS_MODE = 16'hff58;
   localparam logic [15:0] OFS_IRQ_STATUS = 16'hff5c;
   localparam logic [15:0] OFS_IRQ_MASK = 16'hff64;

   // ----------------------------------------------------------
   // reset values and write masks
   // ----------------------------------------------------------
   localparam logic [15:0] BTR_RESET = 16'h370f;
   localparam logic [15:0] BTR_WR_MASK = 16'h370f;
   localparam logic [7:0] PRS_RESET = 8'hff;
   localparam logic [7:0] RHR_LOW_RESET = 8'h02;
   localparam logic MODE_RESET = 1'b1;

   // ----------------------------------------------------------
   // field positions
   // ----------------------------------------------------------
   localparam int SJW_LSB = 12;
   localparam int SJW_W = 2;
   localparam int SEG2_LSB = 8;
   localparam int SEG2_W = 3;
   localparam int SEG1_LSB = 0;
   localparam int SEG1_W = 4;
   localparam int RHR_OVF_BIT = 0;
   localparam int RHR_PM_BIT = 1;
   localparam int MODE_INIT_BIT = 0;
   localparam int IRQ_STORED = 0;
   localparam int IRQ_OVF = 1;
   localparam int IRQ_W = 2;

   // ----------------------------------------------------------
   // history list and timing counters
   // ----------------------------------------------------------
   localparam int HIST_DEPTH = 8;
   localparam int IDX_W = 3;
   localparam int PTR_W = 4;
   localparam int BUF_W = 4;
   localparam int CNT_W = 5;
   localparam int PRS_W = 8;

   typedef enum logic [2:0]
   {
      CBT_SYNC = 3'b001,
      CBT_SEG1 = 3'b010,
      CBT_SEG2 = 3'b100
   } cbt_seg_e;

endpackage

// File: rtl/cbt_top.sv
// can bit timing, time-quantum prescaler and receive history list
// assumes one 50 mhz clock, synchronous rx pin and store strobe,
// and an avalon-mm master that follows waitrequest
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
module cbt_top
(
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic [cbt_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [cbt_pkg::DATA_W-1:0] i_avs_writedata,
   input wire logic [cbt_pkg::BE_W-1:0] i_avs_byteenable,
   output logic [cbt_pkg::DATA_W-1:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_can_rx,
   input wire logic i_store_valid,
   input wire logic [cbt_pkg::BUF_W-1:0] i_store_buf,
   output logic o_tq_pulse,
   output logic o_bit_start,
   output logic o_sample_pulse,
   output logic o_sample_bit,
   output logic o_init_mode,
   output logic o_irq
);
   import cbt_pkg::*;

   // -------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------
   logic rd_ack;
   logic rd_accept;
   logic wr_accept;
   logic [DATA_W-1:0] rd_mux;
   logic [15:0] bit_timing;
   logic [PRS_W-1:0] prescaler;
   logic init_mode;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic [PRS_W-1:0] prs_cnt;
   logic tq;
   cbt_seg_e seg_state;
   logic [CNT_W-1:0] tq_cnt;
   logic [CNT_W-1:0] seg_len;
   logic resynced;
   logic rx_last;
   logic [BUF_W-1:0] hist_mem [HIST_DEPTH];
   logic [PTR_W-1:0] wptr;
   logic [PTR_W-1:0] gptr;
   logic rx_pointer_match;
   logic rx_history_overflow;
   logic [PTR_W-1:0] unread;
   logic [PTR_W-1:0] unread_after;
   logic store;
   logic pop;
   logic ovf_clr;
   logic ovf_set;
   logic [IDX_W-1:0] store_idx;
   logic [PTR_W-1:0] last_ptr;
   logic [BUF_W-1:0] last_in_value;
   logic [BUF_W-1:0] get_value;
   logic [CNT_W-1:0] seg1_q;
   logic [CNT_W-1:0] seg2_q;
   logic [CNT_W-1:0] sjw_q;
   logic [CNT_W-1:0] cnt_inc;
   logic [CNT_W-1:0] ext_q;
   logic [CNT_W-1:0] remain_q;
   logic rx_edge;
   logic seg_done;
   logic [IRQ_W-1:0] irq_events;
   logic [IRQ_W-1:0] irq_clr;

   // -------------------------------------------------------------
   // bus handshake
   // -------------------------------------------------------------
   // reads take one wait state so that read data come from a flop
   assign o_avs_waitrequest = i_avs_read & ~rd_ack;
   assign rd_accept = i_avs_read & rd_ack;
   assign wr_accept = i_avs_write;

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         rd_ack <= 1'b0;
      end
      else
      begin
         rd_ack <= i_avs_read & ~rd_ack;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_avs_readdata <= '0;
      end
      else if (i_avs_read & ~rd_ack)
      begin
         o_avs_readdata <= rd_mux;
      end
   end

   // -------------------------------------------------------------
   // read decode
   // -------------------------------------------------------------
   assign last_ptr = wptr - PTR_W'(1);
   assign last_in_value = hist_mem[last_ptr[IDX_W-1:0]];
   assign get_value = hist_mem[gptr[IDX_W-1:0]];

   always_comb
   begin
      rd_mux = '0;
      if (i_avs_address == OFS_RX_GET)
      begin
         rd_mux[15:8] = {{(8-BUF_W){1'b0}}, get_value};
         rd_mux[RHR_PM_BIT] = rx_pointer_match;
         rd_mux[RHR_OVF_BIT] = rx_history_overflow;
      end
      else if (i_avs_address == OFS_BIT_TIMING)
      begin
         rd_mux[15:0] = bit_timing;
      end
      else if (i_avs_address == OFS_PRESCALER)
      begin
         rd_mux[PRS_W-1:0] = prescaler;
      end
      else if (i_avs_address == OFS_LAST_IN)
      begin
         // undefined content until a frame has been stored
         rd_mux[7:0] = {{(8-BUF_W){1'b0}}, last_in_value};
      end
      else if (i_avs_address == OFS_MODE)
      begin
         rd_mux[MODE_INIT_BIT] = init_mode;
      end
      else if (i_avs_address == OFS_IRQ_STATUS)
      begin
         rd_mux[IRQ_W-1:0] = irq_status;
      end
      else if (i_avs_address == OFS_IRQ_MASK)
      begin
         rd_mux[IRQ_W-1:0] = irq_mask;
      end
   end

   // -------------------------------------------------------------
   // configuration registers
   // -------------------------------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         bit_timing <= BTR_RESET;
      end
      else if (wr_accept && i_avs_address == OFS_BIT_TIMING)
      begin
         if (i_avs_byteenable[0])
         begin
            bit_timing[7:0] <= i_avs_writedata[7:0] & BTR_WR_MASK[7:0];
         end
         if (i_avs_byteenable[1])
         begin
            bit_timing[15:8] <= i_avs_writedata[15:8] & BTR_WR_MASK[15:8];
         end
      end
   end

   // guarded by init mode, unlike bit timing: a change mid-frame would tear a bit apart
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         prescaler <= PRS_RESET;
      end
      else if (wr_accept && i_avs_address == OFS_PRESCALER &&
               i_avs_byteenable[0] && init_mode)
      begin
         prescaler <= i_avs_writedata[PRS_W-1:0];
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         init_mode <= MODE_RESET;
      end
      else if (wr_accept && i_avs_address == OFS_MODE &&
               i_avs_byteenable[0])
      begin
         init_mode <= i_avs_writedata[MODE_INIT_BIT];
      end
   end

   assign o_init_mode = init_mode;

   // -------------------------------------------------------------
   // time-quantum prescaler
   // -------------------------------------------------------------
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         prs_cnt <= '0;
         tq <= 1'b0;
      end
      else if (init_mode)
      begin
         prs_cnt <= '0;
         tq <= 1'b0;
      end
      else if (prs_cnt >= prescaler)
      begin
         prs_cnt <= '0;
         tq <= 1'b1;
      end
      else
      begin
         prs_cnt <= prs_cnt + PRS_W'(1);
         tq <= 1'b0;
      end
   end

   assign o_tq_pulse = tq;

   // -------------------------------------------------------------
   // bit timing
   // -------------------------------------------------------------
   assign seg1_q = CNT_W'(bit_timing[SEG1_LSB +: SEG1_W]) +
                   CNT_W'(1);
   assign seg2_q = CNT_W'(bit_timing[SEG2_LSB +: SEG2_W]) +
                   CNT_W'(1);
   assign sjw_q = CNT_W'(bit_timing[SJW_LSB +: SJW_W]) +
                  CNT_W'(1);
   assign cnt_inc = tq_cnt + CNT_W'(1);
   // late edge: phase error is the quanta since sync, capped
   assign ext_q = (cnt_inc < sjw_q) ? cnt_inc : sjw_q;
   assign remain_q = seg_len - tq_cnt;
   assign rx_edge = tq & rx_last & ~i_can_rx & ~resynced;
   assign seg_done = (tq_cnt >= seg_len - CNT_W'(1));

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         rx_last <= 1'b1;
      end
      else if (tq)
      begin
         rx_last <= i_can_rx;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         seg_state <= CBT_SYNC;
         tq_cnt <= '0;
         seg_len <= '0;
         resynced <= 1'b0;
      end
      else if (init_mode)
      begin
         seg_state <= CBT_SYNC;
         tq_cnt <= '0;
         resynced <= 1'b0;
      end
      else if (tq)
      begin
         case (seg_state)
            CBT_SYNC:
            begin
               // one sync quantum, then segment 1
               seg_state <= CBT_SEG1;
               tq_cnt <= '0;
               seg_len <= seg1_q;
               resynced <= 1'b0;
            end
            CBT_SEG1:
            begin
               if (rx_edge)
               begin
                  seg_len <= seg_len + ext_q;
                  tq_cnt <= cnt_inc;
                  resynced <= 1'b1;
               end
               else if (seg_done)
               begin
                  seg_state <= CBT_SEG2;
                  tq_cnt <= '0;
                  seg_len <= seg2_q;
               end
               else
               begin
                  tq_cnt <= cnt_inc;
               end
            end
            CBT_SEG2:
            begin
               if (rx_edge && remain_q <= sjw_q)
               begin
                  seg_state <= CBT_SYNC;
               end
               else if (rx_edge)
               begin
                  seg_len <= seg_len - sjw_q;
                  tq_cnt <= cnt_inc;
                  resynced <= 1'b1;
               end
               else if (seg_done)
               begin
                  seg_state <= CBT_SYNC;
               end
               else
               begin
                  tq_cnt <= cnt_inc;
               end
            end
            default:
            begin
               seg_state <= CBT_SYNC;
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         o_sample_pulse <= 1'b0;
         o_sample_bit <= 1'b1;
         o_bit_start <= 1'b0;
      end
      else
      begin
         o_bit_start <= tq & ~init_mode & (seg_state == CBT_SYNC);
         // sample point sits at the segment 1 to segment 2 boundary
         o_sample_pulse <= tq & ~init_mode & (seg_state == CBT_SEG1) &
                           ~rx_edge & seg_done;
         if (tq && !init_mode && seg_state == CBT_SEG1 && !rx_edge &&
             seg_done)
         begin
            o_sample_bit <= i_can_rx;
         end
      end
   end

   // -------------------------------------------------------------
   // receive history list
   // -------------------------------------------------------------
   assign store = i_store_valid & ~init_mode;
   assign pop = rd_accept & (i_avs_address == OFS_RX_GET) &
                i_avs_byteenable[1] & ~rx_pointer_match;
   assign ovf_clr = wr_accept & (i_avs_address == OFS_RX_GET) &
                    i_avs_byteenable[0] &
                    i_avs_writedata[RHR_OVF_BIT];
   assign unread = wptr - gptr;
   assign unread_after = unread + PTR_W'(1) - PTR_W'(pop);
   assign ovf_set = store & ~rx_history_overflow &
                    (unread_after == PTR_W'(HIST_DEPTH));
   // in overflow the most recent slot is reused
   assign store_idx = rx_history_overflow ? last_ptr[IDX_W-1:0] :
                      wptr[IDX_W-1:0];

   // list storage needs no reset: pointer-match guards stale data
   always_ff @(posedge i_ref_clk)
   begin
      if (store)
      begin
         hist_mem[store_idx] <= i_store_buf;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         wptr <= '0;
         gptr <= '0;
         rx_pointer_match <= RHR_LOW_RESET[RHR_PM_BIT];
      end
      else if (init_mode)
      begin
         wptr <= '0;
         gptr <= '0;
         rx_pointer_match <= 1'b1;
      end
      else
      begin
         if (store && !rx_history_overflow)
         begin
            wptr <= wptr + PTR_W'(1);
         end
         if (pop)
         begin
            gptr <= gptr + PTR_W'(1);
         end
         if (store && !rx_history_overflow)
         begin
            rx_pointer_match <= 1'b0;
         end
         else if (pop && (gptr + PTR_W'(1)) == wptr)
         begin
            rx_pointer_match <= 1'b1;
         end
      end
   end

   // a new overflow in the clearing cycle wins
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         rx_history_overflow <= RHR_LOW_RESET[RHR_OVF_BIT];
      end
      else if (ovf_set)
      begin
         rx_history_overflow <= 1'b1;
      end
      else if (ovf_clr)
      begin
         rx_history_overflow <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // interrupts
   // -------------------------------------------------------------
   always_comb
   begin
      irq_events = '0;
      irq_events[IRQ_STORED] = store;
      irq_events[IRQ_OVF] = ovf_set;
   end

   assign irq_clr = (wr_accept && i_avs_address == OFS_IRQ_STATUS &&
                     i_avs_byteenable[0]) ?
                    i_avs_writedata[IRQ_W-1:0] : '0;

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         irq_status <= '0;
      end
      else
      begin
         irq_status <= (irq_status & ~irq_clr) | irq_events;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         irq_mask <= '0;
      end
      else if (wr_accept && i_avs_address == OFS_IRQ_MASK &&
               i_avs_byteenable[0])
      begin
         irq_mask <= i_avs_writedata[IRQ_W-1:0];
      end
   end

   assign o_irq = |(irq_status & irq_mask);

endmodule

// File: testbench/cbt_node.sv
// far-side bus node model driving the block's receive line
// assumes the caller shares the block's clock
`timescale 1ns/1ps
module cbt_node
(
   input wire logic i_clk,
   output logic o_rx
);
   // idle bus sits recessive through its pull-up
   initial o_rx = 1'b1;

   task automatic send(input logic [15:0] bits, input int n,
      input int bclk);
      for (int i = n - 1; i >= 0; i--)
      begin
         @(posedge i_clk);
         o_rx <= bits[i];
         repeat (bclk - 1) @(posedge i_clk);
      end
      @(posedge i_clk);
      o_rx <= 1'b1;
   endtask
endmodule

// File: testbench/cbt_top_assertions.sv
// port-level checker for the bit-timing and receive-history block
// assumes it is bound to cbt_top and sees only that module's ports
`timescale 1ns/1ps
module cbt_chk
(
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic [cbt_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [cbt_pkg::DATA_W-1:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic o_tq_pulse,
   input wire logic o_bit_start,
   input wire logic o_sample_pulse,
   input wire logic o_sample_bit,
   input wire logic o_init_mode
);
   import cbt_pkg::*;

   logic rd_ack;
   logic hit_any;

   assign rd_ack = i_avs_read && !o_avs_waitrequest;
   assign hit_any = i_avs_address inside {OFS_RX_GET, OFS_BIT_TIMING,
      OFS_PRESCALER, OFS_LAST_IN, OFS_MODE, OFS_IRQ_STATUS, OFS_IRQ_MASK};

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_reset);

   // ----------------------------------------------------------
   // bus handshake
   // ----------------------------------------------------------
   a_wr_no_wait: assert property (i_avs_write |-> !o_avs_waitrequest)
      else $error("write was held off");
   a_wait_only_read: assert property (o_avs_waitrequest |-> i_avs_read)
      else $error("wait raised without a read");
   a_rd_one_wait: assert property ($rose(i_avs_read) |->
      o_avs_waitrequest ##1 !o_avs_waitrequest)
      else $error("read answer not after one wait cycle");
   a_data_hold: assert property (!i_avs_read |=> $stable(o_avs_readdata))
      else $error("read data moved without a read");
   a_unmapped_zero: assert property (rd_ack && !hit_any |->
      o_avs_readdata == '0)
      else $error("unmapped read not zero");

   // ----------------------------------------------------------
   // register contents and timing
   // ----------------------------------------------------------
   a_btr_mask: assert property (
      rd_ack && i_avs_address == OFS_BIT_TIMING |->
      (o_avs_readdata & ~32'h0000_370f) == '0)
      else $error("bit timing unused bits not zero");
   a_rhr_clean: assert property (
      rd_ack && i_avs_address == OFS_RX_GET |->
      o_avs_readdata[31:16] == '0 && o_avs_readdata[7:2] == '0 &&
      (o_avs_readdata[1] || o_avs_readdata[15:12] == '0))
      else $error("history register has stray bits");
   a_init_halt: assert property (
      o_init_mode && $past(o_init_mode) |->
      !o_tq_pulse && !o_bit_start && !o_sample_pulse)
      else $error("timing ran in init mode");
   a_bit_follow: assert property (
      $changed(o_sample_bit) |-> o_sample_pulse)
      else $error("sampled bit moved off the sample point");
endmodule

bind cbt_top cbt_chk u_chk (.i_ref_clk, .i_reset, .i_avs_address,
   .i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest,
   .o_tq_pulse, .o_bit_start, .o_sample_pulse, .o_sample_bit,
   .o_init_mode);

// File: testbench/test_can_bit_timing_rx_history.sv
// self-checking bench for the bit-timing and receive-history block
// assumes cbt_top, cbt_node and the bound checker are compiled
`timescale 1ns/1ps
module test_can_bit_timing_rx_history;
   import cbt_pkg::*;

   logic i_ref_clk = 1'b0;
   logic reset, rd_en, wr_en, st_v;
   logic [15:0] addr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0] be, st_buf;
   logic waitreq, can_rx, tq, bstart, spulse, sbit, initm, irq;
   int n_mismatch = 0;
   int num_checks = 0;

   cbt_top uut (.i_ref_clk(i_ref_clk), .i_reset(reset),
      .i_avs_address(addr), .i_avs_read(rd_en), .i_avs_write(wr_en),
      .i_avs_writedata(wdata), .i_avs_byteenable(be),
      .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
      .i_can_rx(can_rx), .i_store_valid(st_v), .i_store_buf(st_buf),
      .o_tq_pulse(tq), .o_bit_start(bstart), .o_sample_pulse(spulse),
      .o_sample_bit(sbit), .o_init_mode(initm), .o_irq(irq));
   cbt_node node (.i_clk(i_ref_clk), .o_rx(can_rx));

   initial
   begin
      forever #10 i_ref_clk = ~i_ref_clk;
   end

   // ----------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------
   task automatic wrap_up();
      if (n_mismatch == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic hang();
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 0, 1);
      wrap_up();
   endtask

   task automatic chk(input logic [31:0] got, exp, msk);
      num_checks++;
      if ((got & msk) !== (exp & msk))
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_cnt(input int got, exp);
      num_checks++;
      if (got != exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // request held until waitrequest is seen low at an edge
   task automatic bus(input logic [15:0] a, input logic w,
      input logic [15:0] d);
      int n;
      n = 0;
      @(posedge i_ref_clk);
      addr <= a;
      wdata <= {16'h0000, d};
      wr_en <= w;
      rd_en <= !w;
      do
      begin
         @(posedge i_ref_clk);
         n++;
         if (n > 20)
            hang();
      end
      while (waitreq !== 1'b0);
      rd = rdata;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
   endtask

   task automatic wr(input logic [15:0] a, d);
      bus(a, 1'b1, d);
   endtask

   task automatic rdc(input logic [15:0] a, input logic [31:0] e, m);
      bus(a, 1'b0, 16'h0000);
      chk(rd, e, m);
   endtask

   task automatic store(input logic [3:0] b);
      @(posedge i_ref_clk);
      st_v <= 1'b1;
      st_buf <= b;
      @(posedge i_ref_clk);
      st_v <= 1'b0;
   endtask

   task automatic chk_irq(input logic e);
      @(posedge i_ref_clk);
      chk({31'h0, irq}, {31'h0, e}, 32'h0000_0001);
   endtask

   // clocks from one pulse to the next of tq or bit start
   task automatic gap(input logic which, input int e);
      int n;
      n = 0;
      for (int k = 0; k < 2; k++)
      begin
         do
         begin
            @(posedge i_ref_clk);
            n++;
            if (n > 2000)
               hang();
         end
         while ((which ? bstart : tq) !== 1'b1);
         if (k == 0)
            n = 0;
      end
      chk_cnt(n, e);
   endtask

   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   task automatic t_regs();
      logic [15:0] v;
      rdc(OFS_BIT_TIMING, 32'h0000_370f, '1);
      rdc(OFS_RX_GET, 32'h0000_0002, 32'h0000_00ff);
      rdc(OFS_PRESCALER, 32'h0000_00ff, '1);
      rdc(16'h1234, 32'h0000_0000, '1);
      wr(OFS_BIT_TIMING, 16'hffff);
      rdc(OFS_BIT_TIMING, 32'h0000_370f, '1);
      // code zero of segment 1 is never written
      for (int i = 1; i < 16; i++)
      begin
         v = {2'b00, i[1:0], 1'b0, i[2:0], 4'h0, i[3:0]};
         wr(OFS_BIT_TIMING, v);
         rdc(OFS_BIT_TIMING, {16'h0000, v}, '1);
      end
   endtask

   task automatic t_timing();
      int n;
      chk({31'h0, initm}, 32'h1, 32'h1);
      wr(OFS_PRESCALER, 16'h0002);
      wr(OFS_BIT_TIMING, 16'h3103); // 1 + 4 + 2 quanta
      wr(OFS_MODE, 16'h0000);
      wr(OFS_PRESCALER, 16'h0007);
      // mode write landed one transfer earlier, so it has settled here
      chk({31'h0, initm}, 32'h0, 32'h1);
      rdc(OFS_PRESCALER, 32'h0000_0002, '1);
      gap(1'b0, 3);
      gap(1'b1, 21);
      // idle line: exactly one sample point in any one bit time
      n = 0;
      repeat (21)
      begin
         @(posedge i_ref_clk);
         if (spulse === 1'b1)
            n++;
      end
      chk_cnt(n, 1);
      node.send(16'h0000, 4, 21);
      chk({31'h0, sbit}, 32'h0, 32'h1);
      repeat (42) @(posedge i_ref_clk);
      chk({31'h0, sbit}, 32'h1, 32'h1);
   endtask

   task automatic t_hist();
      store(4'h3);
      store(4'h7);
      rdc(OFS_LAST_IN, 32'h0000_0007, 32'h0000_00ff);
      rdc(OFS_RX_GET, 32'h0000_0300, 32'h0000_ff03);
      rdc(OFS_RX_GET, 32'h0000_0700, 32'h0000_ff03);
      rdc(OFS_RX_GET, 32'h0000_0002, 32'h0000_0003);
      chk_irq(1'b0);
      wr(OFS_IRQ_MASK, 16'h0003);
      chk_irq(1'b1);
      wr(OFS_IRQ_STATUS, 16'h0001);
      chk_irq(1'b0);
   endtask

   task automatic t_ovf();
      logic [7:0] b;
      for (int i = 8; i < 16; i++)
         store(i[3:0]);
      store(4'h5);
      rdc(OFS_LAST_IN, 32'h0000_0005, 32'h0000_00ff);
      for (int i = 0; i < 8; i++)
      begin
         b = (i < 7) ? 8'(8 + i) : 8'h05;
         rdc(OFS_RX_GET, {16'h0, b, 8'h01}, 32'h0000_ff03);
      end
      rdc(OFS_RX_GET, 32'h0000_0003, 32'h0000_0003);
      store(4'h9);
      rdc(OFS_RX_GET, 32'h0000_0003, 32'h0000_0003);
      chk_irq(1'b1);
      wr(OFS_RX_GET, 16'h0000);
      rdc(OFS_RX_GET, 32'h0000_0003, 32'h0000_0003);
      wr(OFS_RX_GET, 16'h0001);
      rdc(OFS_RX_GET, 32'h0000_0002, 32'h0000_0003);
      wr(OFS_IRQ_STATUS, 16'h0003);
      chk_irq(1'b0);
   endtask

   initial
   begin
      reset = 1'b1;
      rd_en = 1'b0;
      wr_en = 1'b0;
      st_v = 1'b0;
      addr = 16'h0000;
      wdata = 32'h0000_0000;
      be = 4'h3;
      st_buf = 4'h0;
      repeat (2) @(posedge i_ref_clk);
      reset <= 1'b0;
      t_regs();
      t_timing();
      t_hist();
      t_ovf();
      wrap_up();
   end
endmodule
